// ### sacf_pkg.sv
// Package for the converter control block: field layouts, codes, timing.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sacf_pkg;
  // ------------------------------------------------------------
  // Channel select codes
  // ------------------------------------------------------------
  localparam int unsigned CHAN_W        = 5;
  localparam int unsigned NUM_CHAN      = 10;
  localparam logic [4:0]  CHAN_OFF      = 5'h1f;
  localparam logic [4:0]  CHAN_RESET    = 5'h1f;
  // ------------------------------------------------------------
  // Result formats
  // ------------------------------------------------------------
  localparam logic [1:0]  FMT_LEFT      = 2'h0;
  localparam logic [1:0]  FMT_RIGHT     = 2'h1;
  localparam logic [1:0]  FMT_LSIGNED   = 2'h2;
  localparam logic [1:0]  FMT_TRUNC8    = 2'h3;
  // ------------------------------------------------------------
  // Conversion timing, in converter clock cycles
  // ------------------------------------------------------------
  localparam int unsigned RES_BITS      = 10;
  localparam logic [9:0]  CODE_FULL     = 10'h3ff;
  localparam logic [9:0]  CODE_ZERO     = 10'h000;
  localparam logic [4:0]  CONV_CYCLES   = 5'h10;
  localparam logic [4:0]  SETTLE_CYCLES = 5'h06;
  localparam logic [7:0]  DIV_RESET     = 8'h00;
  typedef enum logic [1:0] {SACF_IDLE, SACF_WAKE, SACF_SETTLE, SACF_CONV} sacf_state_t;
endpackage : sacf_pkg
`default_nettype wire

// ### sacf_port_pin.sv
// One port pin shared with an analog channel.
// Assumes port data and direction bits come from the port logic outside.
`timescale 1ns/1ps
`default_nettype none
module sacf_port_pin
(
  // Clock
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Port side
  input  wire logic taken,
  input  wire logic port_data,
  input  wire logic port_dir,
  input  wire logic pin_in,
  // Pad side
  output logic      pad_out,
  output logic      pad_oe,
  output logic      port_read
);
  logic oe_next;
  logic rd_next;
  // Selected pin is not driven and reads as zero; port writes have no effect
  assign oe_next = port_dir & ~taken;
  assign rd_next = pin_in & ~taken;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_out   <= 1'b0;
      pad_oe    <= 1'b0;
      port_read <= 1'b0;
    end
    else if (ce)
    begin
      pad_out   <= port_data & ~taken;
      pad_oe    <= oe_next;
      port_read <= rd_next;
    end
  end
endmodule : sacf_port_pin
`default_nettype wire

// ### sacf_ctrl.sv
// Successive-approximation converter control with result formatting.
// Assumes an external DAC/comparator; CPU register strobes arrive as pulses.
`timescale 1ns/1ps
`default_nettype none
module sacf_ctrl
#(
  parameter int unsigned NCH = sacf_pkg::NUM_CHAN
)
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire logic            ce,
  input  wire logic            crystal_clock,
  // Status and control write
  input  wire logic            converter_status_control_wr,
  input  wire logic [4:0]      channel_select_field,
  input  wire logic            continuous_convert_bit,
  input  wire logic            converter_interrupt_enable,
  input  wire logic            flag_wr_value,
  // Clock register
  input  wire logic            converter_clock_source_select,
  input  wire logic [7:0]      clock_divide,
  input  wire logic            result_format_bit_hi,
  input  wire logic            result_format_bit_lo,
  // Result reads
  input  wire logic            result_high_rd,
  input  wire logic            result_low_rd,
  // Analog side
  input  wire logic            comparator_high,
  output logic [9:0]           dac_trial,
  output logic [3:0]           mux_select,
  output logic                 analog_enable,
  // Port pins
  input  wire logic [NCH-1:0]  port_data,
  input  wire logic [NCH-1:0]  port_dir,
  input  wire logic [NCH-1:0]  pin_in,
  output logic [NCH-1:0]       pad_out,
  output logic [NCH-1:0]       pad_oe,
  output logic [NCH-1:0]       port_read,
  // Status
  output logic [7:0]           result_high_reg,
  output logic [7:0]           result_low_reg,
  output logic                 conversion_complete_flag,
  output logic                 irq,
  output logic                 busy
);
  // ------------------------------------------------------------
  // Reset synchroniser
  // ------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  logic [4:0] chan_reg;
  logic       cont_reg;
  logic       ien_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_reg <= sacf_pkg::CHAN_RESET;
      cont_reg <= 1'b0;
      ien_reg  <= 1'b0;
    end
    else if (ce && converter_status_control_wr)
    begin
      chan_reg <= channel_select_field;
      cont_reg <= continuous_convert_bit;
      ien_reg  <= converter_interrupt_enable;
    end
  end
  wire       conv_off  = (chan_reg == sacf_pkg::CHAN_OFF);
  wire       chan_ok   = (chan_reg < 5'(NCH));
  wire [1:0] fmt       = {result_format_bit_hi, result_format_bit_lo};

  // ------------------------------------------------------------
  // Converter clock: crystal edge or bus clock, then divider
  // ------------------------------------------------------------
  logic       xtal_d_reg;
  logic [7:0] div_reg;
  wire        xtal_rise = crystal_clock & ~xtal_d_reg;
  wire        src_tick  = converter_clock_source_select ? xtal_rise : 1'b1;
  wire        div_wrap  = (div_reg >= clock_divide);
  // Divider runs free, so the first cycle after a write may be partial
  wire        adc_tick  = src_tick & div_wrap;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtal_d_reg <= 1'b0;
      div_reg    <= sacf_pkg::DIV_RESET;
    end
    else if (ce)
    begin
      xtal_d_reg <= crystal_clock;
      if (src_tick)
        div_reg <= div_wrap ? sacf_pkg::DIV_RESET : div_reg + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  sacf_pkg::sacf_state_t state_reg;
  sacf_pkg::sacf_state_t state_next;
  logic [4:0] cyc_reg;
  logic [4:0] cyc_next;
  logic [9:0] sar_reg;
  logic [9:0] sar_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic       woke_reg;
  logic       done;

  wire [9:0] trial    = sar_reg | (10'h001 << bit_reg);
  // Sample and bits share the count: 6 settle plus 10 bits = 16 full cycles
  wire start = converter_status_control_wr & ~(channel_select_field == sacf_pkg::CHAN_OFF);
  always_comb
  begin
    state_next = state_reg;
    cyc_next   = cyc_reg;
    sar_next   = sar_reg;
    bit_next   = bit_reg;
    done       = 1'b0;
    if (converter_status_control_wr)
    begin
      // Any write aborts; all-ones code stops the engine
      cyc_next   = 5'h00;
      sar_next   = sacf_pkg::CODE_ZERO;
      bit_next   = 4'h9;
      state_next = !start ? sacf_pkg::SACF_IDLE
                 : (woke_reg ? sacf_pkg::SACF_SETTLE : sacf_pkg::SACF_WAKE);
    end
    else if (adc_tick)
    begin
      case (state_reg)
        sacf_pkg::SACF_WAKE:
          state_next = sacf_pkg::SACF_SETTLE;
        sacf_pkg::SACF_SETTLE:
        begin
          cyc_next = cyc_reg + 5'h01;
          if (cyc_reg == sacf_pkg::SETTLE_CYCLES - 5'h01)
            state_next = sacf_pkg::SACF_CONV;
        end
        sacf_pkg::SACF_CONV:
        begin
          cyc_next = cyc_reg + 5'h01;
          sar_next = comparator_high ? sar_reg : trial;
          bit_next = bit_reg - 4'h1;
          if (bit_reg == 4'h0)
          begin
            done       = 1'b1;
            cyc_next   = 5'h00;
            bit_next   = 4'h9;
            state_next = cont_reg ? sacf_pkg::SACF_SETTLE : sacf_pkg::SACF_IDLE;
            sar_next   = sacf_pkg::CODE_ZERO;
          end
        end
        default:
          state_next = sacf_pkg::SACF_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= sacf_pkg::SACF_IDLE;
      cyc_reg   <= 5'h00;
      sar_reg   <= sacf_pkg::CODE_ZERO;
      bit_reg   <= 4'h9;
      woke_reg  <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
      sar_reg   <= sar_next;
      bit_reg   <= bit_next;
      if (converter_status_control_wr && !start)
        woke_reg <= 1'b0;
      else if (adc_tick && state_reg == sacf_pkg::SACF_WAKE)
        woke_reg <= 1'b1;
    end
  end
  // Final result: last trial bit resolved together with stored bits
  wire [9:0] final_code = comparator_high ? sar_reg : trial;
  // Registered trial must match the bit under test at the next tick
  wire [9:0] trial_next = sar_next | (10'h001 << bit_next);

  // ------------------------------------------------------------
  // Result formatting
  // ------------------------------------------------------------
  logic [7:0] fmt_hi;
  logic [7:0] fmt_lo;
  always_comb
  begin
    case (fmt)
      sacf_pkg::FMT_RIGHT:
      begin
        fmt_hi = {6'h00, final_code[9:8]};
        fmt_lo = final_code[7:0];
      end
      sacf_pkg::FMT_LSIGNED:
      begin
        fmt_hi = {~final_code[9], final_code[8:2]};
        fmt_lo = {final_code[1:0], 6'h00};
      end
      sacf_pkg::FMT_TRUNC8:
      begin
        fmt_hi = 8'h00;
        fmt_lo = final_code[9:2];
      end
      default:
      begin
        fmt_hi = final_code[9:2];
        fmt_lo = {final_code[1:0], 6'h00};
      end
    endcase
  end

  // ------------------------------------------------------------
  // Result store, interlock, flag and interrupt
  // ------------------------------------------------------------
  logic lock_reg;
  logic first_reg;
  logic [7:0] hi_reg;
  logic [7:0] lo_reg;
  logic flag_reg;
  logic irq_reg;
  wire  trunc     = (fmt == sacf_pkg::FMT_TRUNC8);
  wire  store     = done & ce & ~(lock_reg & ~trunc);
  wire  data_rd   = result_high_rd | result_low_rd;
  wire  flag_set  = store & ~ien_reg & (~cont_reg | first_reg);
  wire  flag_clr  = converter_status_control_wr | data_rd;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_reg    <= 8'h00;
      lo_reg    <= 8'h00;
      lock_reg  <= 1'b0;
      first_reg <= 1'b1;
      flag_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end
    else if (ce)
    begin
      if (store)
      begin
        hi_reg <= fmt_hi;
        lo_reg <= fmt_lo;
      end
      // High read arms the lock, low read releases it
      if (result_low_rd || trunc)
        lock_reg <= 1'b0;
      else if (result_high_rd)
        lock_reg <= 1'b1;
      if (converter_status_control_wr)
        first_reg <= 1'b1;
      else if (store)
        first_reg <= 1'b0;
      // Set wins over a simultaneous clear
      if (flag_set)
        flag_reg <= 1'b1;
      else if (flag_clr)
        flag_reg <= ien_reg & converter_status_control_wr & flag_wr_value;
      if (store && ien_reg)
        irq_reg <= 1'b1;
      else if (flag_clr)
        irq_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs and pin takeover
  // ------------------------------------------------------------
  wire active = (state_reg != sacf_pkg::SACF_IDLE);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_trial                <= sacf_pkg::CODE_ZERO;
      mux_select               <= 4'h0;
      analog_enable            <= 1'b0;
      result_high_reg          <= 8'h00;
      result_low_reg           <= 8'h00;
      conversion_complete_flag <= 1'b0;
      irq                      <= 1'b0;
      busy                     <= 1'b0;
    end
    else if (ce)
    begin
      dac_trial                <= trial_next;
      mux_select               <= chan_reg[3:0];
      analog_enable            <= ~conv_off & chan_ok;
      result_high_reg          <= hi_reg;
      result_low_reg           <= lo_reg;
      conversion_complete_flag <= flag_reg;
      irq                      <= irq_reg;
      busy                     <= active;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_pin
      wire taken = ~conv_off & (chan_reg == 5'(g));
      sacf_port_pin u_pin
      (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .taken     (taken),
        .port_data (port_data[g]),
        .port_dir  (port_dir[g]),
        .pin_in    (pin_in[g]),
        .pad_out   (pad_out[g]),
        .pad_oe    (pad_oe[g]),
        .port_read (port_read[g])
      );
    end
  endgenerate
endmodule : sacf_ctrl
`default_nettype wire

// ### sacf_ctrl_props.sv
// Port checker for sacf_ctrl.
// Sees top ports only; one clock domain, reset rstn.
`timescale 1ns/1ps
`default_nettype none
module sacf_ctrl_props
#(
  parameter int unsigned NCH = 10
)
(
  // Requests
  input wire logic           clk,
  input wire logic           rstn,
  input wire logic           ce,
  input wire logic           converter_status_control_wr,
  input wire logic [4:0]     channel_select_field,
  input wire logic           converter_interrupt_enable,
  input wire logic           converter_clock_source_select,
  input wire logic [7:0]     clock_divide,
  // Outputs
  input wire logic [3:0]     mux_select,
  input wire logic           analog_enable,
  input wire logic [NCH-1:0] pad_oe,
  input wire logic [NCH-1:0] port_read,
  input wire logic           conversion_complete_flag,
  input wire logic           irq,
  input wire logic           busy
);
  // ------------------------------
  // Write tracking
  // ------------------------------
  logic       ie_q;
  logic       off_q;
  logic [4:0] chan_q;
  logic [7:0] since_wr;
  wire        wr_t = converter_status_control_wr & ce;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      ie_q     <= 1'b0;
      off_q    <= 1'b1;
      chan_q   <= 5'h1f;
      since_wr <= 8'h00;
    end
    else if (wr_t)
    begin
      ie_q     <= converter_interrupt_enable;
      off_q    <= channel_select_field == 5'h1f;
      chan_q   <= channel_select_field;
      since_wr <= 8'h00;
    end
    else if (since_wr != 8'hff)
      since_wr <= since_wr + 8'h01;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_start;
    wr_t && channel_select_field < 5'd10;
  endsequence
  sequence s_taken;
    analog_enable && mux_select == chan_q[3:0];
  endsequence
  // Two cycles of settled selection, so registered pin paths have caught up
  sequence s_held;
    analog_enable && $past(analog_enable) && $past(analog_enable, 2)
      && $stable(mux_select) && mux_select == $past(mux_select, 2);
  endsequence
  AST_START: assert property (s_start |-> ##[1:3] busy)
    else $error("no busy after start");
  AST_FOLLOW: assert property (s_start |-> ##[1:3] s_taken)
    else $error("channel not routed");
  AST_OFF: assert property (
    wr_t && channel_select_field == 5'h1f |-> ##[1:3] (!busy && !analog_enable))
    else $error("converter not off");
  AST_MIN_LEN: assert property ($fell(busy) && !off_q |-> since_wr >= 8'd16)
    else $error("conversion too short");
  AST_FLAG_TIME: assert property (
    $rose(conversion_complete_flag) && !ie_q && clock_divide == 8'h00
      && !converter_clock_source_select |-> since_wr inside {[8'd15:8'd22]})
    else $error("flag off time");
  AST_RD_ZERO: assert property (s_held |-> port_read[mux_select] == 1'b0)
    else $error("selected pin read not zero");
  AST_OE_OFF: assert property (s_held |-> pad_oe[mux_select] == 1'b0)
    else $error("selected pin driven");
  AST_IRQ_CLR: assert property (
    wr_t && !converter_interrupt_enable |-> ##[1:2] !irq)
    else $error("irq kept after write");
endmodule : sacf_ctrl_props
bind sacf_ctrl sacf_ctrl_props #(.NCH(NCH)) u_props
(
  .clk(clk), .rstn(rstn), .ce(ce),
  .converter_status_control_wr(converter_status_control_wr),
  .channel_select_field(channel_select_field),
  .converter_interrupt_enable(converter_interrupt_enable),
  .converter_clock_source_select(converter_clock_source_select),
  .clock_divide(clock_divide), .mux_select(mux_select), .analog_enable(analog_enable),
  .pad_oe(pad_oe), .port_read(port_read), .irq(irq), .busy(busy),
  .conversion_complete_flag(conversion_complete_flag)
);
`default_nettype wire

// ### sacf_analog_model.sv
// Analog front end: channel levels, multiplexer, comparator.
// Levels come from the bench; above 11'h3ff is over the high reference.
`timescale 1ns/1ps
`default_nettype none
module sacf_analog_model
(
  // Converter side
  input  wire logic [9:0]  dac_trial,
  input  wire logic [3:0]  mux_select,
  input  wire logic        analog_enable,
  output logic             comparator_high,
  // Bench side
  input  wire logic [10:0] level [10]
);
  wire logic [10:0] vin = (mux_select < 4'd10) ? level[mux_select] : 11'h000;
  // Disabled front end answers with dac_trial bit 0 instead of a comparison
  assign comparator_high = analog_enable ? (vin < {1'b0, dac_trial}) : dac_trial[0];
endmodule : sacf_analog_model
`default_nettype wire

// ### sacf_ctrl_tb.sv
// Bench for sacf_ctrl: analog model, result scoreboard, scenarios.
// Assumes package, design, model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module sacf_ctrl_tb;
  logic        clk, rstn, ce, xtal, wr, cont, ie, fwv, src, fh, fl, rdh, rdl;
  logic        cmp, aen, flag, irq, busy, ie_mode, ev_q;
  logic [4:0]  chan;
  logic [7:0]  div, hi, lo;
  logic [3:0]  msel;
  logic [9:0]  trial, pdata, pdir, pin, pout, poe, prd, nsel;
  logic [10:0] level [10];
  logic [10:0] vals [4];
  logic [31:0] q [$];
  logic [31:0] rs, e, r;
  int          n_fail, cmp_count;
  sacf_ctrl dut
  (
    .clk(clk), .rstn(rstn), .ce(ce), .crystal_clock(xtal),
    .converter_status_control_wr(wr), .channel_select_field(chan),
    .continuous_convert_bit(cont), .converter_interrupt_enable(ie), .flag_wr_value(fwv),
    .converter_clock_source_select(src), .clock_divide(div),
    .result_format_bit_hi(fh), .result_format_bit_lo(fl), .result_high_rd(rdh),
    .result_low_rd(rdl), .comparator_high(cmp), .dac_trial(trial), .mux_select(msel),
    .analog_enable(aen), .port_data(pdata), .port_dir(pdir), .pin_in(pin),
    .pad_out(pout), .pad_oe(poe), .port_read(prd), .result_high_reg(hi),
    .result_low_reg(lo), .conversion_complete_flag(flag), .irq(irq), .busy(busy)
  );
  sacf_analog_model u_analog
  (
    .dac_trial(trial), .mux_select(msel), .analog_enable(aen),
    .comparator_high(cmp), .level(level)
  );
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Crystal rises every second bus clock; leaves the unknown start by itself
  always @(posedge clk)
    xtal <= #1 (xtal !== 1'b1);
  initial
  begin
    #1_000_000;
    n_fail++;
    test_done();
  end
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs
  // Packs {high, low, high mask, low mask}
  function automatic logic [31:0] fmt_exp(input logic [9:0] c, input logic [1:0] f);
    case (f)
      sacf_pkg::FMT_LEFT:    return {c[9:2], c[1:0], 6'h00, 16'hffc0};
      sacf_pkg::FMT_RIGHT:   return {6'h00, c, 16'hffff};
      sacf_pkg::FMT_LSIGNED: return {~c[9], c[8:2], c[1:0], 6'h00, 16'hffc0};
      default:               return {8'h00, c[9:2], 16'h00ff};
    endcase
  endfunction : fmt_exp
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp, input string m);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr_ctl(input logic [4:0] c, input logic co, input logic en);
    tick(1);
    {chan, cont, ie, wr} = {c, co, en, 1'b1};
    tick(1);
    wr = 1'b0;
  endtask : wr_ctl
  task automatic wait_done(input int lim);
    int k;
    k = 0;
    while ((flag | irq) !== 1'b1 && k < lim)
    begin
      tick(1);
      k++;
    end
    chk(k < lim, 1'b1, "no completion");
  endtask : wait_done
  task automatic rd(input logic h, input logic l);
    tick(1);
    rdh = h;
    tick(1);
    {rdh, rdl} = {1'b0, l};
    tick(1);
    rdl = 1'b0;
  endtask : rd
  task automatic conv(input logic [3:0] c, input logic [10:0] v, input logic [1:0] f,
                      input int n);
    level[c] = v;
    {fh, fl} = f;
    q.push_back(fmt_exp((v > 11'h3ff) ? 10'h3ff : v[9:0], f));
    wr_ctl({1'b0, c}, 1'b0, ie_mode);
    if (n > 0)
    begin
      tick(n);
      chk(flag | irq, 1'b0, "done early");
    end
    wait_done(300);
    rd(1'b1, 1'b1);
  endtask : conv
  // ------------------------------
  // Scoreboard
  // ------------------------------
  always @(posedge clk)
  begin
    #2;
    if ((flag | irq) === 1'b1 && ev_q !== 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      chk(hi & e[15:8], e[31:24], "result high");
      chk(lo & e[7:0], e[23:16], "result low");
    end
    ev_q = flag | irq;
  end
  initial
  begin
    rs = 32'hafb56c67;
    {rstn, wr, cont, ie, fwv, src, rdh, rdl, ie_mode} = '0;
    {ce, chan, div, fh, fl} = {1'b1, 5'h1f, 8'h00, 2'b01};
    {pdata, pdir, pin} = '0;
    {n_fail, cmp_count} = '0;
    vals = '{11'h000, 11'h3ff, 11'h5a0, 11'h201};
    foreach (level[i])
      level[i] = {1'b0, 10'(xs() >> 22)};
    tick(10);
    rstn = 1'b1;
    tick(3);
    chk({flag, irq, busy, aen}, 4'h0, "reset state");
    for (int i = 0; i < 10; i++)
      conv(i[3:0], {1'b0, 10'(xs() >> 22)}, sacf_pkg::FMT_RIGHT, 0);
    foreach (vals[j])
      for (int f = 0; f < 4; f++)
        conv(4'd7, vals[j], f[1:0], 0);
    conv(4'd2, 11'h155, sacf_pkg::FMT_LEFT, 0);
    rd(1'b1, 1'b0);
    level[2] = 11'h2aa;
    wr_ctl(5'd2, 1'b0, 1'b0);
    tick(40);
    chk(hi, 10'h055, "stored while locked");
    rd(1'b0, 1'b1);
    conv(4'd2, 11'h2aa, sacf_pkg::FMT_LEFT, 0);
    conv(4'd2, 11'h0f0, sacf_pkg::FMT_TRUNC8, 0);
    rd(1'b1, 1'b0);
    conv(4'd2, 11'h30c, sacf_pkg::FMT_TRUNC8, 0);
    wr_ctl(5'd2, 1'b0, 1'b0);
    tick(5);
    conv(4'd5, 11'h0a5, sacf_pkg::FMT_RIGHT, 0);
    wr_ctl(5'h1f, 1'b0, 1'b0);
    tick(30);
    chk({busy, aen}, 2'b00, "running when off");
    conv(4'd9, 11'h3a1, sacf_pkg::FMT_RIGHT, 0);
    div = 8'h03;
    conv(4'd1, 11'h12c, sacf_pkg::FMT_RIGHT, 40);
    {div, src} = {8'h00, 1'b1};
    conv(4'd1, 11'h2d3, sacf_pkg::FMT_RIGHT, 25);
    {src, ie_mode} = 2'b01;
    conv(4'd6, 11'h1e7, sacf_pkg::FMT_RIGHT, 0);
    tick(2);
    chk(irq, 1'b0, "irq kept after read");
    q.push_back(fmt_exp(10'h1e7, sacf_pkg::FMT_RIGHT));
    wr_ctl(5'd6, 1'b0, 1'b1);
    wait_done(300);
    ie_mode = 1'b0;
    conv(4'd6, 11'h1e7, sacf_pkg::FMT_RIGHT, 2);
    {fh, fl, level[3]} = {sacf_pkg::FMT_TRUNC8, 11'h100};
    q.push_back(fmt_exp(10'h100, sacf_pkg::FMT_TRUNC8));
    wr_ctl(5'd3, 1'b1, 1'b0);
    wait_done(300);
    level[3] = 11'h3c4;
    tick(50);
    chk(lo, 10'h0f1, "result not refreshed");
    chk(flag, 1'b1, "flag dropped");
    wr_ctl(5'd3, 1'b0, 1'b0);
    tick(2);
    chk(flag, 1'b0, "flag kept after write");
    tick(60);
    chk(busy, 1'b0, "still converting");
    rd(1'b1, 1'b1);
    for (int i = 4; i < 10; i += 2)
    begin
      conv(i[3:0], 11'h0ff, sacf_pkg::FMT_TRUNC8, 0);
      r = xs();
      {pdata, pdir, pin} = r[29:0];
      nsel = ~(10'h001 << i);
      tick(3);
      chk(prd[i], 1'b0, "selected read not zero");
      chk(poe[i], 1'b0, "selected pin driven");
      chk(poe & nsel, pdir & nsel, "direction lost");
      chk(pout & nsel, pdata & nsel, "port data lost");
    end
    chk(q.size() == 0, 1'b1, "results missing");
    test_done();
  end
endmodule : sacf_ctrl_tb
`default_nettype wire
